// ===== design/ews_regs.svh
// Purpose: constants for the external wait-state controller
// Assumes: one 32-bit configuration word at index 0x2
// Notes:   field positions are lsb positions within the word
`ifndef EWS_REGS_SVH
`define EWS_REGS_SVH
`define EWS_CFG_OFFSET      4'h2
`define EWS_CFG_RESET       32'h21ad6b5a
`define EWS_CFG_RSVD_MASK   32'h7fffffff
`define EWS_BANK_FIELD_W    5
`define EWS_MODE_LSB        0
`define EWS_COUNT_LSB       2
`define EWS_UB_MODE_LSB     20
`define EWS_UB_COUNT_LSB    22
`define EWS_PAGE_SIZE_LSB   25
`define EWS_PAGE_IDLE_BIT   28
`define EWS_MP_WAIT_BIT     29
`define EWS_DMA_IDLE_BIT    30
`define EWS_PAGE_BASE_SHIFT 8
`endif

// ===== design/ews_pkg.sv
// Purpose: types for the external wait-state controller
// Assumes: nothing
// Notes:   state codes are binary and written out
package ews_pkg;
  typedef enum logic [1:0] {
    EWS_MODE_ACK_ONLY = 2'h0,
    EWS_MODE_INT_ONLY = 2'h1,
    EWS_MODE_BOTH     = 2'h2,
    EWS_MODE_EITHER   = 2'h3
  } ews_mode_t;
  typedef enum logic [2:0] {
    EWS_ST_IDLE   = 3'h0,
    EWS_ST_PRE    = 3'h1,
    EWS_ST_STROBE = 3'h2,
    EWS_ST_HOLD   = 3'h3,
    EWS_ST_BIDLE  = 3'h4
  } ews_state_t;
endpackage : ews_pkg

// ===== design/ews_cfg_reg.sv
// Purpose: configuration word storage with processor register port
// Assumes: writes are single-cycle strobes, synchronous to clock
// Notes:   read data is registered, reserved bit reads as zero
`timescale 1ns/100ps
`default_nettype none
`include "ews_regs.svh"
module ews_cfg_reg (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  output var  logic [31:0] cfg,
  output var  logic [31:0] rd_data
);
  logic [31:0] cfg_r, cfg_nxt, rd_r, rd_nxt;

  // next word: write replaces, reserved bit forced low
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_en) begin
      cfg_nxt = wr_data & `EWS_CFG_RSVD_MASK;
    end
    rd_nxt = cfg_r;
  end

  // reset value loads on processor reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `EWS_CFG_RESET;
      rd_r  <= `EWS_CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
      rd_r  <= rd_nxt;
    end
  end

  assign cfg     = cfg_r;
  assign rd_data = rd_r;
endmodule : ews_cfg_reg
`default_nettype wire

// ===== design/ews_reset_sync.sv
// Purpose: reset release synchroniser
// Assumes: reset_n may be asynchronous
// Notes:   assertion is immediate, release takes two edges
`timescale 1ns/100ps
`default_nettype none
module ews_reset_sync (
  input  wire logic clock,
  input  wire logic reset_n,
  output var  logic rst_n
);
  logic meta_r, sync_r, meta_nxt, sync_nxt;

  // second stage reads only the first
  always_comb begin
    meta_nxt = 1'b1;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign rst_n = sync_r;
endmodule : ews_reset_sync
`default_nettype wire

// ===== design/ews_wait_ctrl.sv
// Purpose: wait-state and bus-cycle sequencing for the external port
// Assumes: core holds its request until done; inputs synchronous
// Notes:   one access at a time; inactive cycles follow or precede it
`timescale 1ns/100ps
`default_nettype none
`include "ews_regs.svh"
module ews_wait_ctrl #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              reg_wr,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  output var  logic [31:0]       reg_rdata,
  input  wire logic              acc_req,
  input  wire logic              acc_write,
  input  wire logic [1:0]        acc_bank,
  input  wire logic              acc_boot_sel,
  input  wire logic              acc_mp_space,
  input  wire logic              acc_dma_hs,
  input  wire logic [ADDR_W-1:0] acc_addr,
  input  wire logic [DATA_W-1:0] acc_wdata,
  output logic                   acc_done,
  output logic [ADDR_W-1:0]      ext_addr,
  output logic [DATA_W-1:0]      ext_wdata,
  output logic                   ext_drive,
  output logic                   ext_rd_n,
  output logic                   ext_wr_n,
  output logic                   ext_bms_n,
  input  wire logic              ext_ack
);
  logic        rst_n;
  logic [31:0] cfg;
  logic [31:0] rd_word;

  ews_reset_sync u_rst (
    .clock   (clock),
    .reset_n (reset_n),
    .rst_n   (rst_n)
  );

  // register port decode, one word at its documented index
  ews_cfg_reg u_cfg (
    .clock   (clock),
    .rst_n   (rst_n),
    .wr_en   (reg_wr && (reg_addr == `EWS_CFG_OFFSET)),
    .wr_data (reg_wdata),
    .cfg     (cfg),
    .rd_data (rd_word)
  );

  // wait count decode: 111 means zero waits, not seven
  function automatic logic [2:0] waits_of(input logic [2:0] code);
    waits_of = (code == 3'h7) ? 3'h0 : code;
  endfunction : waits_of

  function automatic logic idle_of(input logic [2:0] code);
    idle_of = (code == 3'h1) || (code == 3'h2) ||
              (code == 3'h3) || (code == 3'h7);
  endfunction : idle_of

  function automatic logic hold_of(input logic [2:0] code);
    hold_of = (code == 3'h4) || (code == 3'h5) ||
              (code == 3'h6);
  endfunction : hold_of

  // sequencer state
  ews_pkg::ews_state_t state_r, state_nxt;
  ews_pkg::ews_mode_t  mode_r, mode_nxt;
  logic [2:0]          cnt_r, cnt_nxt;
  logic                hold_r, hold_nxt;
  logic                idle_r, idle_nxt;
  logic                wr_r, wr_nxt;
  logic                bms_r, bms_nxt;
  logic                done_r, done_nxt;
  logic [ADDR_W-1:0]   addr_r, addr_nxt, last_addr_r, last_addr_nxt;
  logic [DATA_W-1:0]   data_r, data_nxt;
  logic                last_valid_r, last_valid_nxt;
  logic                cnt_zero, finish;

  // field selection for the current access
  logic [4:0]          bank_field;
  ews_pkg::ews_mode_t  sel_mode;
  logic [2:0]          sel_code;
  logic [2:0]          page_size;
  logic                page_cross;
  always_comb begin
    bank_field = cfg[5'(acc_bank) * 5 +: `EWS_BANK_FIELD_W];
    sel_mode   = ews_pkg::ews_mode_t'(bank_field[1:0]);
    sel_code   = bank_field[4:2];
    if (acc_boot_sel) begin
      sel_mode = ews_pkg::ews_mode_t'(cfg[`EWS_UB_MODE_LSB +: 2]);
      sel_code = cfg[`EWS_UB_COUNT_LSB +: 3];
    end
    page_size  = cfg[`EWS_PAGE_SIZE_LSB +: 3];
    // page is 2^(8+size) words; only bank 0 checks it
    page_cross = !acc_boot_sel && (acc_bank == 2'h0) &&
                 last_valid_r &&
                 ((acc_addr >> (`EWS_PAGE_BASE_SHIFT + page_size)) !=
                  (last_addr_r >> (`EWS_PAGE_BASE_SHIFT + page_size)));
  end

  // completion decision per mode, ack sampled once per clock
  always_comb begin
    cnt_zero = (cnt_r == 3'h0);
    case (mode_r)
      ews_pkg::EWS_MODE_ACK_ONLY: finish = ext_ack;
      ews_pkg::EWS_MODE_INT_ONLY: finish = cnt_zero;
      ews_pkg::EWS_MODE_BOTH:     finish = cnt_zero && ext_ack;
      ews_pkg::EWS_MODE_EITHER:   finish = cnt_zero || ext_ack;
      default:                    finish = 1'b0;
    endcase
  end

  // next-state logic for the access sequencer
  always_comb begin
    state_nxt      = state_r;
    mode_nxt       = mode_r;
    cnt_nxt        = cnt_r;
    hold_nxt       = hold_r;
    idle_nxt       = idle_r;
    wr_nxt         = wr_r;
    bms_nxt        = bms_r;
    addr_nxt       = addr_r;
    data_nxt       = data_r;
    done_nxt       = 1'b0;
    last_addr_nxt  = last_addr_r;
    last_valid_nxt = last_valid_r;
    case (state_r)
      ews_pkg::EWS_ST_IDLE: begin
        if (acc_req && !done_r) begin
          // latch everything so the bus stays stable while stretched
          mode_nxt = sel_mode;
          cnt_nxt  = waits_of(sel_code) +
                     3'(acc_mp_space && cfg[`EWS_MP_WAIT_BIT]);
          hold_nxt = hold_of(sel_code);
          idle_nxt = idle_of(sel_code);
          wr_nxt   = acc_write;
          bms_nxt  = acc_boot_sel;
          addr_nxt = acc_addr;
          data_nxt = acc_wdata;
          // only bank 0 accesses move the page reference
          if (!acc_boot_sel && (acc_bank == 2'h0)) begin
            last_addr_nxt  = acc_addr;
            last_valid_nxt = 1'b1;
          end
          if ((page_cross && cfg[`EWS_PAGE_IDLE_BIT]) ||
              (acc_dma_hs && cfg[`EWS_DMA_IDLE_BIT])) begin
            state_nxt = ews_pkg::EWS_ST_PRE;
          end else begin
            state_nxt = ews_pkg::EWS_ST_STROBE;
          end
        end
      end
      ews_pkg::EWS_ST_PRE: begin
        state_nxt = ews_pkg::EWS_ST_STROBE;
      end
      ews_pkg::EWS_ST_STROBE: begin
        if (!cnt_zero) begin
          cnt_nxt = cnt_r - 3'h1;
        end
        if (finish) begin
          if (hold_r) begin
            state_nxt = ews_pkg::EWS_ST_HOLD;
          end else if (idle_r) begin
            state_nxt = ews_pkg::EWS_ST_BIDLE;
          end else begin
            state_nxt = ews_pkg::EWS_ST_IDLE;
            done_nxt  = 1'b1;
          end
        end
      end
      ews_pkg::EWS_ST_HOLD, ews_pkg::EWS_ST_BIDLE: begin
        state_nxt = ews_pkg::EWS_ST_IDLE;
        done_nxt  = 1'b1;
      end
      default: state_nxt = ews_pkg::EWS_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= ews_pkg::EWS_ST_IDLE;
      mode_r       <= ews_pkg::EWS_MODE_ACK_ONLY;
      cnt_r        <= 3'h0;
      hold_r       <= 1'b0;
      idle_r       <= 1'b0;
      wr_r         <= 1'b0;
      bms_r        <= 1'b0;
      done_r       <= 1'b0;
      addr_r       <= '0;
      data_r       <= '0;
      last_addr_r  <= '0;
      last_valid_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      mode_r       <= mode_nxt;
      cnt_r        <= cnt_nxt;
      hold_r       <= hold_nxt;
      idle_r       <= idle_nxt;
      wr_r         <= wr_nxt;
      bms_r        <= bms_nxt;
      done_r       <= done_nxt;
      addr_r       <= addr_nxt;
      data_r       <= data_nxt;
      last_addr_r  <= last_addr_nxt;
      last_valid_r <= last_valid_nxt;
    end
  end

  // pin outputs registered from state; strobes only during STROBE
  logic              rd_n_r, wr_n_r, bms_n_r, drive_r;
  logic [ADDR_W-1:0] eaddr_r;
  logic [DATA_W-1:0] edata_r;
  logic              strobe_on, bus_on;
  always_comb begin
    strobe_on = (state_nxt == ews_pkg::EWS_ST_STROBE);
    // hold cycle keeps address and data driven after the strobe
    bus_on    = strobe_on || (state_nxt == ews_pkg::EWS_ST_HOLD);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_n_r  <= 1'b1;
      wr_n_r  <= 1'b1;
      bms_n_r <= 1'b1;
      drive_r <= 1'b0;
      eaddr_r <= '0;
      edata_r <= '0;
    end else begin
      rd_n_r  <= !(strobe_on && !wr_nxt);
      wr_n_r  <= !(strobe_on && wr_nxt);
      bms_n_r <= !(strobe_on && bms_nxt);
      drive_r <= bus_on && wr_nxt;
      eaddr_r <= addr_nxt;
      edata_r <= data_nxt;
    end
  end

  assign reg_rdata = rd_word;
  assign acc_done  = done_r;
  assign ext_addr  = eaddr_r;
  assign ext_wdata = edata_r;
  assign ext_drive = drive_r;
  assign ext_rd_n  = rd_n_r;
  assign ext_wr_n  = wr_n_r;
  assign ext_bms_n = bms_n_r;

  // checks
  property p_mode1_ignores_ack;
    @(posedge clock) disable iff (!rst_n)
      (state_r == ews_pkg::EWS_ST_STROBE &&
       mode_r == ews_pkg::EWS_MODE_INT_ONLY && !cnt_zero)
      |=> state_r == ews_pkg::EWS_ST_STROBE;
  endproperty
  a_mode1_ignores_ack: assert property (p_mode1_ignores_ack)
    else $error("internal-only access ended early");
  property p_ack_only;
    @(posedge clock) disable iff (!rst_n)
      (state_r == ews_pkg::EWS_ST_STROBE &&
       mode_r == ews_pkg::EWS_MODE_ACK_ONLY && !ext_ack)
      |=> state_r == ews_pkg::EWS_ST_STROBE;
  endproperty
  a_ack_only: assert property (p_ack_only)
    else $error("ack-only access ended without ack");
  property p_both;
    @(posedge clock) disable iff (!rst_n)
      (state_r == ews_pkg::EWS_ST_STROBE &&
       mode_r == ews_pkg::EWS_MODE_BOTH && (!ext_ack || !cnt_zero))
      |=> state_r == ews_pkg::EWS_ST_STROBE;
  endproperty
  a_both: assert property (p_both)
    else $error("both-mode access ended too soon");
  property p_either;
    @(posedge clock) disable iff (!rst_n)
      (state_r == ews_pkg::EWS_ST_STROBE &&
       mode_r == ews_pkg::EWS_MODE_EITHER && ext_ack)
      |=> state_r != ews_pkg::EWS_ST_STROBE;
  endproperty
  a_either: assert property (p_either)
    else $error("either-mode access ignored ack");
  property p_hold_keeps_bus;
    @(posedge clock) disable iff (!rst_n)
      $rose(ext_rd_n) && state_r == ews_pkg::EWS_ST_HOLD
      |-> $stable(ext_addr) ##1 acc_done;
  endproperty
  a_hold_keeps_bus: assert property (p_hold_keeps_bus)
    else $error("hold cycle lost address");
  property p_stable_addr;
    @(posedge clock) disable iff (!rst_n)
      !ext_rd_n && !$past(ext_rd_n) |-> $stable(ext_addr);
  endproperty
  a_stable_addr: assert property (p_stable_addr)
    else $error("address moved during strobe");
  property p_done_pulse;
    @(posedge clock) disable iff (!rst_n)
      acc_done |=> !acc_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_idle_after;
    @(posedge clock) disable iff (!rst_n)
      state_r == ews_pkg::EWS_ST_BIDLE |-> ext_rd_n && ext_wr_n && !ext_drive;
  endproperty
  a_idle_after: assert property (p_idle_after)
    else $error("bus active in idle cycle");
  c_hold: cover property (@(posedge clock) state_r == ews_pkg::EWS_ST_HOLD);
  c_bidle: cover property (@(posedge clock) state_r == ews_pkg::EWS_ST_BIDLE);
  c_pre: cover property (@(posedge clock) state_r == ews_pkg::EWS_ST_PRE);
endmodule : ews_wait_ctrl
`default_nettype wire

// ===== tb/ews_ext_mem.sv
// Purpose: external memory model answering strobes with acknowledge
// Assumes: strobes are active low and registered by the controller
// Notes:   delay is the strobe cycles that pass before acknowledge
`timescale 1ns/100ps
`default_nettype none
module ews_ext_mem (
  input  wire logic       clock,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [2:0] delay,
  output var  logic       ack
);
  logic [3:0] low_cnt_r;
  // restart on every release so each access sees its own delay
  always_ff @(posedge clock) begin
    if (rd_n && wr_n) low_cnt_r <= 4'h0;
    else if (low_cnt_r != 4'hf) low_cnt_r <= low_cnt_r + 4'h1;
  end
  // ack only inside a strobe, so no stale ack ends the next access
  always_comb begin
    ack = !(rd_n && wr_n) && (low_cnt_r >= {1'b0, delay});
  end
endmodule : ews_ext_mem
`default_nettype wire

// ===== tb/external_wait_state_control_tb.sv
// Purpose: self-checking bench for the wait-state controller
// Assumes: inputs change at the falling edge, outputs read 1ns after rise
// Notes:   strobe length, lead and tail are measured per access
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module external_wait_state_control_tb;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        acc_req = 1'b0;
  logic        acc_write = 1'b0;
  logic [1:0]  acc_bank = 2'h0;
  logic        acc_boot_sel = 1'b0;
  logic        acc_mp_space = 1'b0;
  logic        acc_dma_hs = 1'b0;
  logic [31:0] acc_addr = 32'h0;
  logic [31:0] acc_wdata = 32'h0;
  logic [2:0]  ack_delay = 3'h0;
  logic [31:0] reg_rdata, ext_addr, ext_wdata, cfg_w;
  logic        acc_done, ext_drive, ext_rd_n, ext_wr_n, ext_bms_n, ext_ack;
  logic [4:0]  fld;
  logic [1:0]  bk;
  logic        bt, mp;
  logic [2:0]  dly;
  int          fails = 0;
  int          compares = 0;

  // 25 MHz
  always #20 clock = ~clock;

  ews_wait_ctrl dut (.clock(clock), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .acc_req(acc_req), .acc_write(acc_write), .acc_bank(acc_bank),
    .acc_boot_sel(acc_boot_sel), .acc_mp_space(acc_mp_space),
    .acc_dma_hs(acc_dma_hs), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_done(acc_done), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_drive(ext_drive), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
    .ext_bms_n(ext_bms_n), .ext_ack(ext_ack));

  ews_ext_mem mem (.clock(clock), .rd_n(ext_rd_n), .wr_n(ext_wr_n),
    .delay(ack_delay), .ack(ext_ack));

  // strobe cycles expected for a mode, count code, extra wait and ack delay
  function automatic int exp_len(input logic [1:0] m, input logic [2:0] c,
                                 input logic x, input logic [2:0] d);
    int w;
    int a;
    w = ((c == 3'h7) ? 0 : int'(c)) + 1 + int'(x);
    a = int'(d) + 1;
    case (m)
      2'h0: return a;
      2'h1: return w;
      2'h2: return (w > a) ? w : a;
      default: return (w < a) ? w : a;
    endcase
  endfunction : exp_len

  task automatic set_cfg(input logic [3:0] a, input logic [31:0] v,
                         input logic [31:0] e);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clock);
    reg_wr = 1'b0;
    @(negedge clock);
    `CHK(reg_rdata, e)
  endtask : set_cfg

  // one access; epre below zero skips the lead check
  task automatic acc(input logic wr, input logic [1:0] b, input logic s,
    input logic x, input logic dh, input logic [2:0] d,
    input logic [31:0] ad, input int epre, input int elen,
    input logic [2:0] c);
    int n;
    logic hd;
    logic [31:0] wd;
    wd = $urandom;
    hd = (c >= 3'h4) && (c <= 3'h6);
    @(negedge clock);
    acc_req = 1'b1;
    acc_write = wr;
    acc_bank = b;
    acc_boot_sel = s;
    acc_mp_space = x;
    acc_dma_hs = dh;
    acc_addr = ad;
    acc_wdata = wd;
    ack_delay = d;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while ((wr ? ext_wr_n : ext_rd_n) !== 1'b0 && n < 40);
    if (epre >= 0) `CHK(n, epre)
    n = 0;
    // strobe phase: address, data and select must stand still
    while ((wr ? ext_wr_n : ext_rd_n) === 1'b0 && n < 40) begin
      `CHK(ext_addr, ad)
      `CHK(ext_bms_n, ~s)
      if (wr) `CHK(ext_wdata, wd)
      `CHK(ext_drive, wr)
      `CHK(wr ? ext_rd_n : ext_wr_n, 1'b1)
      @(posedge clock);
      #1;
      n++;
    end
    `CHK(n, elen)
    n = 0;
    while (acc_done !== 1'b1 && n < 40) begin
      if (hd) `CHK(ext_addr, ad)
      if (hd && wr) `CHK(ext_drive, 1'b1)
      @(posedge clock);
      #1;
      n++;
    end
    `CHK(n, (c != 3'h0) ? 1 : 0)
    @(negedge clock);
    acc_req = 1'b0;
  endtask : acc

  // bank read with zero waits, internal mode, to look at the lead
  task automatic pg(input logic [1:0] b, input logic dh,
                    input logic [31:0] ad, input int epre);
    acc(1'b0, b, 1'b0, 1'b0, dh, 3'h0, ad, epre, 1, 3'h0);
  endtask : pg

  task automatic reset_dut();
    @(negedge clock);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    `CHK(reg_rdata, 32'h21ad6b5a)
  endtask : reset_dut

  task automatic print_verdict();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  initial begin
    void'($urandom(32'h9d0b7d70));
    reset_dut();
    set_cfg(4'h3, 32'h0, 32'h21ad6b5a); // unmapped index is ignored
    set_cfg(4'h2, 32'hffffffff, 32'h7fffffff);
    $display("test registers finished");
    // every mode with every code; codes 1..3 are for slow devices
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 8; c++) begin
        fld = {3'(c), 2'(m)};
        set_cfg(4'h2, {7'h0, {5{fld}}}, {7'h0, {5{fld}}});
        acc(1'($urandom), 2'($urandom), 1'b0, 1'b0, 1'b0, 3'h3, $urandom,
            1, exp_len(fld[1:0], fld[4:2], 1'b0, 3'h3), fld[4:2]);
      end
    end
    $display("test modes finished");
    // independent random field per bank, so a wrong field shows up
    for (int i = 0; i < 30; i++) begin
      cfg_w = {2'h0, 1'($urandom), 4'h0, 25'($urandom)};
      bk = 2'($urandom);
      bt = 1'($urandom);
      fld = bt ? cfg_w[24:20] : cfg_w[5 * bk +: 5];
      mp = (fld[1:0] != 2'h0) ? 1'($urandom) : 1'b0;
      set_cfg(4'h2, cfg_w, cfg_w);
      dly = 3'($urandom);
      acc(1'($urandom), bk, bt, mp, 1'b0, dly, $urandom, 1,
          exp_len(fld[1:0], fld[4:2], mp & cfg_w[29], dly),
          fld[4:2]);
    end
    $display("test random finished");
    set_cfg(4'h2, {7'h08, {5{5'h01}}}, {7'h08, {5{5'h01}}});
    pg(2'h0, 1'b0, 32'h10, -1);
    pg(2'h0, 1'b0, 32'h20, 1);
    pg(2'h0, 1'b0, 32'h110, 2);
    pg(2'h1, 1'b0, 32'h300, 1);
    pg(2'h0, 1'b0, 32'h120, 1);
    set_cfg(4'h2, {7'h09, {5{5'h01}}}, {7'h09, {5{5'h01}}});
    pg(2'h0, 1'b0, 32'h1f0, 1);
    pg(2'h0, 1'b0, 32'h210, 2);
    set_cfg(4'h2, {7'h20, {5{5'h01}}}, {7'h20, {5{5'h01}}});
    pg(2'h0, 1'b0, 32'h5000, 1);
    pg(2'h2, 1'b1, 32'h40, 2);
    pg(2'h2, 1'b0, 32'h44, 1);
    set_cfg(4'h2, {7'h00, {5{5'h01}}}, {7'h00, {5{5'h01}}});
    pg(2'h2, 1'b1, 32'h48, 1);
    $display("test page and handshake finished");
    reset_dut();
    $display("test second reset finished");
    print_verdict();
  end

  // the tests take under a thousand cycles; this allows ten thousand
  initial begin
    #400000;
    fails++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule : external_wait_state_control_tb
`default_nettype wire
